//--- src/i2c_ms_ctrl.sv
// Purpose: two-wire bus master/slave controller with APB registers
// Assumes: pin inputs synchronous to clk, 20 MHz clock
// Notes: bytes stretch the clock until software touches the data register
`include "i2c_ms_ctrl_regs.svh"

module i2c_ms_ctrl (
   input logic clk,                  // system clock
   input logic rst_n,                // async reset, active low
   input logic [7:0] paddr,          // apb address
   input logic psel,                 // apb select
   input logic penable,              // apb enable
   input logic pwrite,               // apb direction
   input logic [31:0] pwdata,        // apb write data
   output logic [31:0] prdata,       // apb read data
   output logic pready,              // apb ready
   output logic pslverr,             // apb error, unmapped
   output logic irq,                 // level interrupt
   input logic stop3_halt,           // freeze while high
   input logic stop2_entry,          // reset registers
   input logic port_f_line_two_in,   // clock line, pos 0
   output logic port_f_line_two_out, // always low level
   output logic port_f_line_two_oe,  // pull low
   input logic port_f_line_three_in, // data line, pos 0
   output logic port_f_line_three_out, // always low level
   output logic port_f_line_three_oe, // pull low
   input logic port_e_line_four_in,  // clock line, pos 1
   output logic port_e_line_four_out, // always low level
   output logic port_e_line_four_oe, // pull low
   input logic port_e_line_five_in,  // data line, pos 1
   output logic port_e_line_five_out, // always low level
   output logic port_e_line_five_oe  // pull low
);

   logic [1:0] rs_q;
   logic rstn_s;
   i2c_ms_pkg::state_t s;
   i2c_ms_pkg::state_t n;
   logic scl;
   logic sda;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic acc;
   logic wr;
   logic dwr;
   logic drd;
   logic kick;
   logic rsta;
   logic done;
   logic lose;
   logic m7;
   logic gc;
   logic t1;
   logic [11:0] h;
   logic [2:0] ev;
   logic [2:0] clr;
   logic [31:0] rd;

   // half of one serial bit in clocks; divider never below 20
   function automatic logic [11:0] half_per(input logic [1:0] m,
                                            input logic [5:0] i);
      logic [8:0] d;
      d = {1'b0, i, 2'b00};
      case (i)
         6'h00: d = 9'h014;
         6'h01: d = 9'h016;
         6'h02: d = 9'h018;
         6'h03: d = 9'h01a;
         6'h04: d = 9'h01c;
         6'h05: d = 9'h01e;
         6'h06: d = 9'h022;
         6'h07: d = 9'h028;
         6'h08: d = 9'h01c;
         6'h09: d = 9'h020;
         6'h0a: d = 9'h024;
         6'h0b: d = 9'h028;
         6'h0c: d = 9'h02c;
         default: d = {1'b0, i, 2'b00};
      endcase
      // reserved multiplier acts as one
      if (m == 2'h1) begin
         half_per = {3'h0, d};
      end else if (m == 2'h2) begin
         half_per = {2'h0, d, 1'b0};
      end else begin
         half_per = {4'h0, d[8:1]};
      end
   endfunction

   // state value after any reset, including stop2 entry
   function automatic i2c_ms_pkg::state_t rst_val();
      i2c_ms_pkg::state_t r;
      r = '0;
      r.mul = `MUL_RST;
      r.rate_divider_index = `ICR_RST;
      r.pos = `POS_RST;
      r.ms = i2c_ms_pkg::M_IDLE;
      r.sclp = 1'b1;
      r.sdap = 1'b1;
      rst_val = r;
   endfunction

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rs_q <= 2'h0;
      end else begin
         rs_q <= {rs_q[0], 1'b1};
      end
   end
   assign rstn_s = rs_q[1];

   // line selection by pin position
   assign scl = s.pos ? port_e_line_four_in : port_f_line_two_in;
   assign sda = s.pos ? port_e_line_five_in : port_f_line_three_in;
   assign rise = ~s.sclp & scl;
   assign fall = s.sclp & ~scl;
   assign start = s.sclp & scl & s.sdap & ~sda;
   assign stop = s.sclp & scl & ~s.sdap & sda;

   // apb: one wait state, write and read effects at the ready edge
   assign acc = psel & penable & s.pready;
   assign wr = acc & pwrite;
   assign dwr = wr & (paddr == `A_DATA);
   assign drd = acc & ~pwrite & (paddr == `A_DATA);
   assign kick = (dwr | drd) & s.hold;
   assign rsta = wr & (paddr == `A_CTRL) & pwdata[`C_RSTA];
   assign h = half_per(s.mul, s.rate_divider_index);
   assign done = (s.cnt == h - 12'h001);

   // read mux
   always_comb begin
      rd = 32'h0000_0000;
      if (paddr == `A_OWN) begin
         rd[7:1] = s.own;
      end else if (paddr == `A_FREQ) begin
         rd[7:0] = {s.mul, s.rate_divider_index};
      end else if (paddr == `A_CTRL) begin
         rd[7:0] = {s.en, 1'b0, s.mst, s.tx, s.txak, 1'b0, s.gce, s.ten};
      end else if (paddr == `A_STAT) begin
         rd[7:0] = {s.hold, s.aas, s.busy, s.act, 1'b0, s.srw, 1'b0, s.rxak};
      end else if (paddr == `A_DATA) begin
         rd[7:0] = s.dat;
      end else if (paddr == `A_IST) begin
         rd[2:0] = s.ist;
      end else if (paddr == `A_IMSK) begin
         rd[2:0] = s.imsk;
      end else if (paddr == `A_AHI) begin
         rd[2:0] = s.ahi;
      end else if (paddr == `A_SOPT) begin
         rd[0] = s.pos;
      end
   end

   // next-state logic; later steps override earlier ones
   always_comb begin
      n = s;
      ev = 3'h0;
      clr = 3'h0;
      lose = 1'b0;
      m7 = 1'b0;
      gc = 1'b0;
      t1 = 1'b0;
      n.sclp = scl;
      n.sdap = sda;
      n.pready = psel & penable & ~s.pready;
      n.prdata = 32'h0000_0000;
      n.pslverr = 1'b0;
      if (psel & penable & ~s.pready) begin
         n.prdata = rd;
         n.pslverr = ~((paddr == `A_OWN) | (paddr == `A_FREQ) |
                       (paddr == `A_CTRL) | (paddr == `A_STAT) |
                       (paddr == `A_DATA) | (paddr == `A_IST) |
                       (paddr == `A_IMSK) | (paddr == `A_AHI) |
                       (paddr == `A_SOPT));
      end
      // register writes
      if (wr) begin
         if (paddr == `A_OWN) begin
            n.own = pwdata[7:1];
         end else if (paddr == `A_FREQ) begin
            n.mul = pwdata[7:6];
            n.rate_divider_index = pwdata[5:0];
         end else if (paddr == `A_CTRL) begin
            n.en = pwdata[`C_EN];
            n.mst = pwdata[`C_MST];
            n.tx = pwdata[`C_TX];
            n.txak = pwdata[`C_TXAK];
            n.gce = pwdata[`C_GCE];
            n.ten = pwdata[`C_TEN];
         end else if (paddr == `A_IST) begin
            clr = pwdata[2:0];
         end else if (paddr == `A_IMSK) begin
            n.imsk = pwdata[2:0];
         end else if (paddr == `A_AHI) begin
            n.ahi = pwdata[2:0];
         end else if (paddr == `A_SOPT) begin
            n.pos = pwdata[0];
         end
      end
      // software touching data resumes a held byte
      if (kick) begin
         n.hold = 1'b0;
         n.act = 1'b1;
         n.bitn = 4'h0;
         if (dwr) begin
            n.sh = pwdata[7:0];
         end
         n.sda_oe = s.tx & dwr & ~pwdata[7];
         if (!s.mst) begin
            n.scl_oe = 1'b0;
         end
      end
      // master clock and condition generator
      case (s.ms)
         i2c_ms_pkg::M_IDLE: begin
            if (s.mst && s.en && !s.busy) begin
               n.sda_oe = 1'b1;
               n.cnt = 12'h000;
               n.ms = i2c_ms_pkg::M_START;
            end else if (s.mst) begin
               lose = 1'b1;
            end
         end
         i2c_ms_pkg::M_START: begin
            n.cnt = s.cnt + 12'h001;
            if (done) begin
               n.scl_oe = 1'b1;
               n.cnt = 12'h000;
               n.hold = 1'b1;
               n.ms = i2c_ms_pkg::M_WAIT;
            end
         end
         i2c_ms_pkg::M_WAIT: begin
            n.cnt = 12'h000;
            if (!s.mst) begin
               n.sda_oe = 1'b1;
               n.ms = i2c_ms_pkg::M_STOP;
            end else if (rsta) begin
               n.sda_oe = 1'b0;
               n.ms = i2c_ms_pkg::M_RSTA;
            end else if (kick) begin
               n.ms = i2c_ms_pkg::M_LOW;
            end
         end
         i2c_ms_pkg::M_LOW: begin
            n.cnt = s.cnt + 12'h001;
            if (done) begin
               n.scl_oe = 1'b0;
               n.cnt = 12'h000;
               n.ms = i2c_ms_pkg::M_HIGH;
            end
         end
         i2c_ms_pkg::M_HIGH: begin
            // count only once the line is seen high: slaves may stretch
            if (scl) begin
               n.cnt = s.cnt + 12'h001;
               if (done) begin
                  n.scl_oe = 1'b1;
                  n.cnt = 12'h000;
                  n.ms = (s.bitn == 4'h9) ? i2c_ms_pkg::M_WAIT : i2c_ms_pkg::M_LOW;
               end
            end
         end
         i2c_ms_pkg::M_STOP: begin
            n.cnt = s.cnt + 12'h001;
            if (done) begin
               n.scl_oe = 1'b0;
               n.cnt = 12'h000;
               n.ms = i2c_ms_pkg::M_STOP2;
            end
         end
         i2c_ms_pkg::M_STOP2: begin
            if (scl) begin
               n.cnt = s.cnt + 12'h001;
               if (done) begin
                  n.sda_oe = 1'b0;
                  n.hold = 1'b0;
                  n.cnt = 12'h000;
                  n.ms = i2c_ms_pkg::M_IDLE;
               end
            end
         end
         i2c_ms_pkg::M_RSTA: begin
            n.cnt = s.cnt + 12'h001;
            if (done) begin
               n.scl_oe = 1'b0;
               n.cnt = 12'h000;
               n.ms = i2c_ms_pkg::M_RHI;
            end
         end
         i2c_ms_pkg::M_RHI: begin
            if (scl) begin
               n.cnt = s.cnt + 12'h001;
               if (done) begin
                  n.sda_oe = 1'b1;
                  n.cnt = 12'h000;
                  n.ms = i2c_ms_pkg::M_START;
               end
            end
         end
         default: begin
            n.ms = i2c_ms_pkg::M_IDLE;
         end
      endcase
      // bus monitor sees every start and stop, own ones too
      if (start) begin
         n.busy = 1'b1;
         n.bitn = 4'h0;
         n.aas = 1'b0;
         if (!s.mst) begin
            n.aph = 1'b1;
            n.act = s.en;
            n.hold = 1'b0;
            n.sda_oe = 1'b0;
            n.scl_oe = 1'b0;
         end
      end else if (stop) begin
         n.busy = 1'b0;
         n.act = 1'b0;
         n.aas = 1'b0;
         n.aph = 1'b0;
         n.tw = 1'b0;
         n.tenok = 1'b0;
         if (!s.mst) begin
            n.hold = 1'b0;
            n.sda_oe = 1'b0;
            n.scl_oe = 1'b0;
         end
      end else if (s.act && rise) begin
         // sample on the rising clock edge
         if (s.bitn < 4'h8) begin
            n.sh = {s.sh[6:0], sda};
            n.bitn = s.bitn + 4'h1;
            // released a one but the line reads zero
            if (s.mst && s.tx && !s.sda_oe && !sda) begin
               lose = 1'b1;
            end
         end else if (s.bitn == 4'h8) begin
            n.rxak = sda;
            n.bitn = 4'h9;
         end
      end else if (s.act && fall) begin
         if (s.bitn < 4'h8) begin
            n.sda_oe = s.tx & ~s.sh[7];
         end else if (s.bitn == 4'h8 && s.aph && !s.mst) begin
            // address byte as slave: decide the acknowledge
            m7 = ~s.ten & (s.sh[7:1] == s.own);
            gc = s.gce & (s.sh == `GC_ADDR);
            t1 = s.ten & (s.sh[7:3] == `TEN_HDR) & (s.sh[2:1] == s.ahi[2:1]);
            n.sda_oe = 1'b1;
            if (s.tw) begin
               n.tw = 1'b0;
               n.aph = 1'b0;
               if ({s.ahi[0], s.own} == s.sh) begin
                  n.aas = 1'b1;
                  n.tenok = 1'b1;
                  n.srw = 1'b0;
                  n.tx = 1'b0;
                  ev[`I_AAS] = 1'b1;
               end else begin
                  n.sda_oe = 1'b0;
                  n.act = 1'b0;
               end
            end else if (m7 || gc || (t1 && s.sh[0] && s.tenok)) begin
               n.aas = 1'b1;
               n.aph = 1'b0;
               n.srw = s.sh[0];
               n.tx = s.sh[0] & ~gc;
               ev[`I_AAS] = 1'b1;
            end else if (t1 && !s.sh[0]) begin
               n.tw = 1'b1;
            end else begin
               n.sda_oe = 1'b0;
               n.act = 1'b0;
               n.aph = 1'b0;
            end
         end else if (s.bitn == 4'h8) begin
            n.sda_oe = ~s.tx & ~s.txak;
         end else if (s.bitn == 4'h9) begin
            n.sda_oe = 1'b0;
            if (s.tw) begin
               // second address byte follows with no software step
               n.bitn = 4'h0;
            end else begin
               n.act = 1'b0;
               n.dat = s.sh;
               ev[`I_BYTE] = 1'b1;
               // a nack to our slave transmit ends our part
               if (!(s.tx && !s.mst && s.rxak)) begin
                  n.hold = 1'b1;
                  n.scl_oe = s.scl_oe | ~s.mst; // master already holds it low
               end
            end
         end
      end
      // lost arbitration: release both lines and act as slave
      if (lose) begin
         n.mst = 1'b0;
         n.tx = 1'b0;
         n.act = 1'b0;
         n.hold = 1'b0;
         n.scl_oe = 1'b0;
         n.sda_oe = 1'b0;
         n.ms = i2c_ms_pkg::M_IDLE;
         ev[`I_ARBL] = 1'b1;
      end
      // disabled module leaves the bus alone
      if (!n.en) begin
         n.act = 1'b0;
         n.hold = 1'b0;
         n.aas = 1'b0;
         n.aph = 1'b0;
         n.scl_oe = 1'b0;
         n.sda_oe = 1'b0;
         n.ms = i2c_ms_pkg::M_IDLE;
      end
      // an event in the clearing cycle survives
      n.ist = (s.ist & ~clr) | ev;
      // enables only: the wire is pulled low or let float
      n.pin_lvl = 4'h0;
      n.pin_oe = n.pos ? {n.sda_oe, n.scl_oe, 2'b00} : {2'b00, n.sda_oe, n.scl_oe};
      // irq runs in wait mode too, so it can wake the cpu
      n.irq = |(n.ist & n.imsk);
      if (stop2_entry) begin
         n = rst_val();
      end else if (stop3_halt) begin
         n = s;
      end
   end

   // single state register
   always_ff @(posedge clk or negedge rstn_s) begin
      if (!rstn_s) begin
         s <= rst_val();
      end else begin
         s <= n;
      end
   end

   // outputs straight from the state register
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign irq = s.irq;
   assign port_f_line_two_oe = s.pin_oe[0];
   assign port_f_line_three_oe = s.pin_oe[1];
   assign port_e_line_four_oe = s.pin_oe[2];
   assign port_e_line_five_oe = s.pin_oe[3];
   assign port_f_line_two_out = s.pin_lvl[0];
   assign port_f_line_three_out = s.pin_lvl[1];
   assign port_e_line_four_out = s.pin_lvl[2];
   assign port_e_line_five_out = s.pin_lvl[3];

endmodule // i2c_ms_ctrl

//--- inc/i2c_ms_ctrl_regs.svh
// Purpose: offsets, field positions and reset values of the two-wire bus controller
// Assumes: 32-bit APB data, one aligned word per register, byte addresses below
// Notes: codes of the controller state machine live in the package
`ifndef I2C_MS_CTRL_REGS_SVH
`define I2C_MS_CTRL_REGS_SVH

// register byte addresses
`define A_OWN 8'h00
`define A_FREQ 8'h04
`define A_CTRL 8'h08
`define A_STAT 8'h0c
`define A_DATA 8'h10
`define A_IST 8'h14
`define A_IMSK 8'h18
`define A_AHI 8'h1c
`define A_SOPT 8'h20

// control register bits
`define C_EN 7
`define C_MST 5
`define C_TX 4
`define C_TXAK 3
`define C_RSTA 2
`define C_GCE 1
`define C_TEN 0

// interrupt status and mask bits
`define I_BYTE 0
`define I_ARBL 1
`define I_AAS 2

// address constants and reset values
`define GC_ADDR 8'h00
`define TEN_HDR 5'h1e
`define MUL_RST 2'h0
`define ICR_RST 6'h00
`define POS_RST 1'h0

`endif

//--- inc/i2c_ms_pkg.sv
// Purpose: types shared by the two-wire bus controller
// Assumes: constants come from the register header
// Notes: whole controller state is one packed struct
package i2c_ms_pkg;

   // master clock and condition generator
   typedef enum logic [3:0] {
      M_IDLE  = 4'b0000,
      M_START = 4'b0001,
      M_WAIT  = 4'b0010,
      M_LOW   = 4'b0011,
      M_HIGH  = 4'b0100,
      M_STOP  = 4'b0101,
      M_STOP2 = 4'b0110,
      M_RSTA  = 4'b0111,
      M_RHI   = 4'b1000
   } mst_st_t;

   typedef struct packed {
      logic [6:0] own;
      logic [2:0] ahi;
      logic [1:0] mul;
      logic [5:0] rate_divider_index;
      logic en;
      logic mst;
      logic tx;
      logic txak;
      logic gce;
      logic ten;
      logic pos;
      logic [2:0] ist;
      logic [2:0] imsk;
      logic [7:0] sh;
      logic [7:0] dat;
      logic [3:0] bitn;
      logic act;
      logic hold;
      logic aph;
      logic tw;
      logic tenok;
      logic aas;
      logic srw;
      logic rxak;
      logic busy;
      logic sclp;
      logic sdap;
      logic scl_oe;
      logic sda_oe;
      mst_st_t ms;
      logic [11:0] cnt;
      logic [3:0] pin_oe;
      logic [3:0] pin_lvl;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
   } state_t;

endpackage

//--- dv/i2c_ms_ctrl_checker.sv
// Purpose: port-level checks of the two-wire controller
// Assumes: bench resolves the wired lines onto the _in ports
// Notes: only the port f pair is watched for line timing
module i2c_ms_ctrl_checker (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic irq, // level interrupt
   input wire logic stop3_halt, // freeze
   input wire logic stop2_entry, // register reset
   input wire logic port_f_line_two_in, // clock wire
   input wire logic port_f_line_two_out, // clock drive level
   input wire logic port_f_line_two_oe, // clock pull
   input wire logic port_f_line_three_oe, // data pull
   input wire logic port_e_line_four_oe, // clock pull, pos 1
   input wire logic port_e_line_five_oe // data pull, pos 1
);
   int wr_age;
   // cycles since the last write access, saturating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) wr_age <= 0;
      else if (psel && penable && pwrite) wr_age <= 0;
      else if (wr_age < 15) wr_age <= wr_age + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence start_gen;
      $rose(port_f_line_three_oe) && port_f_line_two_in;
   endsequence
   sequence clk_kept_high;
      port_f_line_two_in [*8];
   endsequence
   chk_lines_low: assert property (port_f_line_two_oe |-> !port_f_line_two_out)
      else $error("clock line driven high");
   chk_pos_excl: assert property (!((port_f_line_two_oe || port_f_line_three_oe) &&
      (port_e_line_four_oe || port_e_line_five_oe)))
      else $error("both pin positions driven");
   chk_clk_low: assert property (disable iff (!rst_n || stop2_entry)
      $rose(port_f_line_two_oe) |=> port_f_line_two_oe [*8])
      else $error("serial clock low phase too short");
   chk_start_hold: assert property (disable iff (!rst_n || stop2_entry)
      start_gen |=> clk_kept_high)
      else $error("clock fell too soon after start");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("error outside access phase");
   chk_data_idle: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside ready");
   chk_irq_fall: assert property ($fell(irq) |-> wr_age <= 3 || $past(stop2_entry))
      else $error("interrupt dropped without software");
   chk_halt_freeze: assert property (stop3_halt && !stop2_entry |=>
      $stable({pready, irq, port_f_line_two_oe, port_f_line_three_oe}))
      else $error("activity while halted");
   chk_stop2_clear: assert property (stop2_entry |=>
      !irq && !pready && !port_f_line_two_oe && !port_f_line_three_oe)
      else $error("state kept over stop2 entry");
endmodule // i2c_ms_ctrl_checker

bind i2c_ms_ctrl i2c_ms_ctrl_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq(irq), .stop3_halt(stop3_halt), .stop2_entry(stop2_entry),
   .port_f_line_two_in(port_f_line_two_in), .port_f_line_two_out(port_f_line_two_out),
   .port_f_line_two_oe(port_f_line_two_oe), .port_f_line_three_oe(port_f_line_three_oe),
   .port_e_line_four_oe(port_e_line_four_oe), .port_e_line_five_oe(port_e_line_five_oe));

//--- dv/i2c_peer.sv
// Purpose: slave on the far side of the two-wire bus
// Assumes: lines pulled up, sampled on clk
// Notes: never stretches the clock; grab fakes another master
module i2c_peer (
   input wire logic clk, // system clock
   input wire logic scl, // resolved clock line
   input wire logic sda, // resolved data line
   input wire logic ack_en, // answer with ack
   input wire logic grab, // hold data low
   output logic sda_pull, // pull data low
   output logic [7:0] rx, // last byte seen
   output int starts, // starts seen
   output int stops // stops seen
);
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   logic ackp = 1'b0;
   int bitc = 0;
   initial begin
      starts = 0;
      stops = 0;
   end
   // follow the wire, count bits, ack on the ninth
   always @(posedge clk) begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
         starts <= starts + 1;
         bitc <= 0;
      end else if (scl && scl_q && !sda_q && sda) begin
         stops <= stops + 1;
      end else if (scl && !scl_q) begin
         bitc <= bitc + 1;
         if (bitc < 8) rx <= {rx[6:0], sda};
      end else if (!scl && scl_q) begin
         ackp <= (bitc == 8) && ack_en;
         if (bitc == 9) bitc <= 0;
      end
   end
   // only ever pulls low, release floats high
   assign sda_pull = grab | ackp;
endmodule // i2c_peer

//--- dv/tb_top.sv
// Purpose: self-checking bench for the two-wire controller
// Assumes: apb answers with one wait state
// Notes: peer sits on the pair chosen by pos
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic stop3_halt = 0, stop2_entry = 0, pos = 0, ack_en = 1, grab = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v, rs = 32'h0000_3b8d;
   logic pready, pslverr, irq, er, pull, f2_oe, f3_oe, e4_oe, e5_oe;
   logic [7:0] rx;
   int starts, stops, n_fail = 0, tests_run = 0, cyc = 0, n;
   // pulled-up wires, any pull wins
   wire scl_f = !f2_oe;
   wire sda_f = !(f3_oe | (!pos & pull));
   wire scl_e = !e4_oe;
   wire sda_e = !(e5_oe | (pos & pull));
   always #25 clk = ~clk;
   i2c_ms_ctrl u_i2c_ms_ctrl (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .stop3_halt(stop3_halt), .stop2_entry(stop2_entry),
      .port_f_line_two_in(scl_f), .port_f_line_two_out(), .port_f_line_two_oe(f2_oe),
      .port_f_line_three_in(sda_f), .port_f_line_three_out(), .port_f_line_three_oe(f3_oe),
      .port_e_line_four_in(scl_e), .port_e_line_four_out(), .port_e_line_four_oe(e4_oe),
      .port_e_line_five_in(sda_e), .port_e_line_five_out(), .port_e_line_five_oe(e5_oe));
   i2c_peer u_i2c_peer (.clk(clk), .scl(pos ? scl_e : scl_f), .sda(pos ? sda_e : sda_f),
      .ack_en(ack_en), .grab(grab), .sda_pull(pull), .rx(rx), .starts(starts), .stops(stops));
   function logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   // own address keeps bits 7 to 1 only
   function logic [31:0] own_view(input logic [31:0] x);
      return x & 32'h0000_00fe;
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, held until ready is sampled
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      // no local limit: the hang guard ends a wait that never answers
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
      int k;
      k = 0;
      do begin
         apb(1'b0, a, 32'h0);
         k++;
      end while ((rd & m) !== want && k < 150);
   endtask
   task cyc_wait(input int c);
      repeat (c) @(posedge clk);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         complete_run();
      end
   end
   initial begin
      cyc_wait(16);
      rst_n <= 1;
      cyc_wait(3);
      for (int a = 0; a <= 32; a += 4) begin
         apb(1'b0, a[7:0], 32'h0);
         chk(rd, 32'h0, "reset value");
      end
      apb(1'b1, 8'h24, 32'h0000_00ff);
      chk(er, 1, "unmapped error");
      repeat (8) begin
         v = xs();
         apb(1'b1, 8'h00, v);
         apb(1'b0, 8'h00, 32'h0);
         chk(rd, own_view(v), "own address");
         apb(1'b1, 8'h04, v);
         apb(1'b0, 8'h04, 32'h0);
         chk(rd, v & 32'h0000_00ff, "rate setting");
      end
      // master send: address acked, then a data byte nacked
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h18, 32'h0000_0007);
      apb(1'b1, 8'h08, 32'h0000_00b0);
      poll(8'h0c, 32'h80, 32'h80);
      chk(starts, 1, "start on wire");
      for (int b = 0; b < 2; b++) begin
         v = own_view(xs());
         apb(1'b1, 8'h10, v);
         n = 0;
         while (irq !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
         end
         chk(rx, v, "byte on wire");
         apb(1'b0, 8'h0c, 32'h0);
         chk(rd & 32'h21, 32'h20 | b, "ack and busy");
         apb(1'b0, 8'h14, 32'h0);
         chk(rd, 32'h1, "byte event");
         apb(1'b1, 8'h14, 32'h1);
         cyc_wait(3);
         chk(irq, 0, "irq cleared");
         ack_en <= 0;
      end
      // repeated start, then stop
      apb(1'b1, 8'h08, 32'h0000_00b4);
      n = 0;
      while (starts < 2 && n < 600) begin
         @(posedge clk);
         n++;
      end
      chk(starts, 2, "repeated start");
      chk(stops, 0, "no stop before restart");
      apb(1'b1, 8'h08, 32'h0000_0090);
      poll(8'h0c, 32'h20, 32'h0);
      chk(stops, 1, "stop on wire");
      // another master holds the bus, masked then unmasked
      grab <= 1;
      cyc_wait(4);
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h08, 32'h0000_00b0);
      cyc_wait(4);
      chk(irq, 0, "masked interrupt");
      apb(1'b0, 8'h14, 32'h0);
      chk(rd & 32'h2, 32'h2, "arbitration lost");
      apb(1'b0, 8'h08, 32'h0);
      chk(rd & 32'h20, 32'h0, "fell to slave");
      apb(1'b1, 8'h18, 32'h0000_0002);
      cyc_wait(3);
      chk(irq, 1, "unmasked interrupt");
      // halted, then registers reset
      stop3_halt <= 1;
      cyc_wait(6);
      chk(irq, 1, "irq kept in halt");
      stop3_halt <= 0;
      grab <= 0;
      cyc_wait(4);
      stop2_entry <= 1;
      cyc_wait(1);
      stop2_entry <= 0;
      cyc_wait(3);
      chk(irq, 0, "irq after stop2");
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0, "own after stop2");
      apb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h0, "mask after stop2");
      // second pin position
      pos <= 1;
      apb(1'b1, 8'h20, 32'h1);
      apb(1'b1, 8'h08, 32'h0000_00b0);
      n = 0;
      while (e5_oe !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(e5_oe, 1, "data on port e");
      chk(f2_oe | f3_oe, 0, "port f idle");
      apb(1'b1, 8'h08, 32'h0000_0090);
      poll(8'h0c, 32'h20, 32'h0);
      complete_run();
   end
endmodule // tb_top
